// File: design/cycle_timing_pkg.sv
// constants for the machine-cycle sequencer
package cycle_timing_pkg;
    localparam int unsigned states_per_cycle = 4;
    localparam logic [2:0] stretch_reset = 3'h1;
    localparam int unsigned stretch_field_lsb = 0;
    localparam int unsigned idle_bit_pos = 0;
    localparam logic [15:0] pc_reset = 16'h0000;
    localparam logic [7:0] sp_reset = 8'h07;
    localparam int unsigned reset_hold_cycles = 2;
    localparam int unsigned wdt_reset_delay_clocks = 512;
    localparam logic [9:0] wdt_delay_last = 10'h1ff;
    localparam logic [4:0] strobe_clocks_zero = 5'h02;
    localparam logic [4:0] strobe_clocks_per_unit = 5'h04;
    localparam logic [7:0] opcode_ljmp = 8'h02;
    localparam logic [7:0] opcode_lcall = 8'h12;
    localparam logic [7:0] opcode_external_data_move_rd = 8'he0;
    localparam logic [7:0] opcode_external_data_move_wr = 8'hf0;
    typedef enum logic [1:0] {
        cycle_state_one = 2'b00,
        cycle_state_two = 2'b01,
        cycle_state_three = 2'b10,
        cycle_state_four = 2'b11
    } cycle_state_t;
    typedef enum logic [1:0] {
        seq_fetch = 2'b00,
        seq_exec = 2'b01,
        seq_xdata = 2'b10,
        seq_idle = 2'b11
    } seq_mode_t;
endpackage

// File: design/cycle_ctl_if.sv
// signals between the sequencer and its helpers
`timescale 1ns/10ps
`default_nettype none
interface cycle_ctl_if;
    logic [1:0] phase;
    logic cycle_end;
    logic hold;
    logic [7:0] opcode;
    logic [2:0] total_cycles;
    logic is_jump;
    logic is_external_data_move;
    logic external_data_move_write;
    modport seq (input phase, input cycle_end, output hold, output opcode, input total_cycles, input is_jump,
        input is_external_data_move, input external_data_move_write);
    modport phs (output phase, output cycle_end, input hold);
    modport dec (input opcode, output total_cycles, output is_jump, output is_external_data_move, output external_data_move_write);
endinterface
`default_nettype wire

// File: design/cycle_phase_gen.sv
// four-state machine cycle phase counter
`timescale 1ns/10ps
`default_nettype none
module cycle_phase_gen (
    input wire logic mclk,
    input wire logic rst_b,
    cycle_ctl_if.phs ctl
);
    cycle_timing_pkg::cycle_state_t phase_r;
    cycle_timing_pkg::cycle_state_t phase_nxt;

    always_comb
    begin
        phase_nxt = phase_r;
        if (!ctl.hold)
        begin
            case (phase_r)
                cycle_timing_pkg::cycle_state_one: phase_nxt = cycle_timing_pkg::cycle_state_two;
                cycle_timing_pkg::cycle_state_two: phase_nxt = cycle_timing_pkg::cycle_state_three;
                cycle_timing_pkg::cycle_state_three: phase_nxt = cycle_timing_pkg::cycle_state_four;
                cycle_timing_pkg::cycle_state_four: phase_nxt = cycle_timing_pkg::cycle_state_one;
                default: phase_nxt = cycle_timing_pkg::cycle_state_one;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            phase_r <= cycle_timing_pkg::cycle_state_one;
        else
            phase_r <= phase_nxt;
    end

    assign ctl.phase = phase_r;
    assign ctl.cycle_end = (phase_r == cycle_timing_pkg::cycle_state_four) && !ctl.hold;
endmodule
`default_nettype wire

// File: design/cycle_length_decode.sv
// opcode to machine-cycle count decoder
`timescale 1ns/10ps
`default_nettype none
module cycle_length_decode (
    cycle_ctl_if.dec ctl
);
    logic [2:0] base;
    logic jump;

    always_comb
    begin
        jump = (ctl.opcode == cycle_timing_pkg::opcode_ljmp) || (ctl.opcode == cycle_timing_pkg::opcode_lcall)
            || (ctl.opcode[4:0] == 5'h01) || (ctl.opcode[4:0] == 5'h11);
        if (!ctl.opcode[7])
            base = 3'h1;
        else if (ctl.opcode[6:5] == 2'h3)
            base = 3'h2;
        else
            base = {1'b0, ctl.opcode[1:0]} + 3'h1;
        if (jump && base < 3'h5)
            base = base + 3'h1;
        ctl.total_cycles = base;
        ctl.is_jump = jump;
        ctl.is_external_data_move = (ctl.opcode == cycle_timing_pkg::opcode_external_data_move_rd)
            || (ctl.opcode == cycle_timing_pkg::opcode_external_data_move_wr);
        ctl.external_data_move_write = (ctl.opcode == cycle_timing_pkg::opcode_external_data_move_wr);
    end
endmodule
`default_nettype wire

// File: design/cpu_cycle_timing_stretch_idle.sv
// machine-cycle sequencer with stretched data moves and idle mode
`timescale 1ns/10ps
`default_nettype none
module cpu_cycle_timing_stretch_idle #(
    parameter int unsigned wdt_delay = cycle_timing_pkg::wdt_reset_delay_clocks
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic rst_pin,
    input wire logic [7:0] code_byte,
    input wire logic stretch_wr,
    input wire logic [2:0] stretch_wdata,
    input wire logic idle_wr,
    input wire logic idle_wdata,
    input wire logic irq_pending,
    input wire logic wdt_timeout,
    input wire logic wdt_clear,
    input wire logic wdt_reset_en,
    input wire logic [15:0] xdata_addr_in,
    input wire logic [7:0] port_in,
    output logic [15:0] code_addr,
    output logic fetch_strobe,
    output logic ale,
    output logic program_store_strobe_n,
    output logic [15:0] xdata_addr,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] port_out,
    output logic [1:0] cycle_state,
    output logic core_clk_en,
    output logic idle_active,
    output logic [2:0] data_access_stretch_sel,
    output logic internal_reset,
    output logic irq_ack,
    output logic instr_done
);
    cycle_ctl_if ctl ();

    cycle_phase_gen u_phase (
        .mclk(mclk),
        .rst_b(rst_b),
        .ctl(ctl)
    );

    cycle_length_decode u_dec (
        .ctl(ctl)
    );

    cycle_timing_pkg::seq_mode_t mode_r;
    cycle_timing_pkg::seq_mode_t mode_nxt;
    logic [2:0] stretch_r;
    logic [2:0] stretch_nxt;
    logic idle_bit_r;
    logic idle_bit_nxt;
    logic [15:0] pc_r;
    logic [15:0] pc_nxt;
    logic [7:0] opcode_r;
    logic [7:0] opcode_nxt;
    logic [2:0] cyc_left_r;
    logic [2:0] cyc_left_nxt;
    logic [4:0] strobe_cnt_r;
    logic [4:0] strobe_cnt_nxt;
    logic xwrite_r;
    logic xwrite_nxt;
    logic rd_n_r;
    logic rd_n_nxt;
    logic wr_n_r;
    logic wr_n_nxt;
    logic [15:0] xaddr_r;
    logic [15:0] xaddr_nxt;
    logic [7:0] port_r;
    logic [7:0] port_nxt;
    logic [1:0] rst_seen_r;
    logic [1:0] rst_seen_nxt;
    logic [1:0] rst_hold_r;
    logic [1:0] rst_hold_nxt;
    logic wdt_arm_r;
    logic wdt_arm_nxt;
    logic [9:0] wdt_cnt_r;
    logic [9:0] wdt_cnt_nxt;
    logic irq_ack_r;
    logic irq_ack_nxt;
    logic done_r;
    logic done_nxt;
    logic fetch_r;
    logic fetch_nxt;

    logic core_rst;
    logic wdt_fire;
    logic [9:0] wdt_last;

    assign wdt_last = 10'(wdt_delay - 1);
    assign wdt_fire = wdt_arm_r && wdt_reset_en && (wdt_cnt_r == wdt_last);
    assign core_rst = (rst_hold_r != 2'h0) || wdt_fire;

    // reset sampling, watchdog delay, hold counter
    always_comb
    begin
        rst_seen_nxt = rst_seen_r;
        rst_hold_nxt = rst_hold_r;
        wdt_arm_nxt = wdt_arm_r;
        wdt_cnt_nxt = wdt_cnt_r;
        if (ctl.phase == cycle_timing_pkg::cycle_state_four || ctl.hold)
        begin
            rst_seen_nxt = {rst_seen_r[0], rst_pin};
            if (rst_seen_r[0] && rst_pin)
                rst_hold_nxt = 2'(cycle_timing_pkg::reset_hold_cycles);
            else if (rst_hold_r != 2'h0)
                rst_hold_nxt = rst_hold_r - 2'h1;
        end
        if (wdt_fire)
            rst_hold_nxt = 2'(cycle_timing_pkg::reset_hold_cycles);
        if (wdt_fire)
        begin
            wdt_arm_nxt = 1'b0;
            wdt_cnt_nxt = 10'h000;
        end
        else if (wdt_timeout && !wdt_arm_r)
        begin
            wdt_arm_nxt = 1'b1;
            wdt_cnt_nxt = 10'h000;
        end
        else if (wdt_clear)
        begin
            wdt_arm_nxt = 1'b0;
            wdt_cnt_nxt = 10'h000;
        end
        else if (wdt_arm_r)
            wdt_cnt_nxt = wdt_cnt_r + 10'h001;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_seen_r <= 2'h0;
            rst_hold_r <= 2'h0;
            wdt_arm_r <= 1'b0;
            wdt_cnt_r <= 10'h000;
        end
        else
        begin
            rst_seen_r <= rst_seen_nxt;
            rst_hold_r <= rst_hold_nxt;
            wdt_arm_r <= wdt_arm_nxt;
            wdt_cnt_r <= wdt_cnt_nxt;
        end
    end

    // core sequencer
    always_comb
    begin
        mode_nxt = mode_r;
        stretch_nxt = stretch_r;
        idle_bit_nxt = idle_bit_r;
        pc_nxt = pc_r;
        opcode_nxt = opcode_r;
        cyc_left_nxt = cyc_left_r;
        strobe_cnt_nxt = strobe_cnt_r;
        xwrite_nxt = xwrite_r;
        rd_n_nxt = 1'b1;
        wr_n_nxt = 1'b1;
        xaddr_nxt = xaddr_r;
        port_nxt = port_r;
        irq_ack_nxt = 1'b0;
        done_nxt = 1'b0;
        fetch_nxt = 1'b0;
        if (stretch_wr && mode_r != cycle_timing_pkg::seq_idle)
            stretch_nxt = stretch_wdata;
        if (idle_wr && idle_wdata && mode_r != cycle_timing_pkg::seq_idle)
            idle_bit_nxt = 1'b1;
        if (mode_r != cycle_timing_pkg::seq_idle)
            port_nxt = port_in;
        case (mode_r)
            cycle_timing_pkg::seq_fetch:
            begin
                if (ctl.cycle_end)
                begin
                    fetch_nxt = 1'b1;
                    opcode_nxt = code_byte;
                    pc_nxt = pc_r + 16'h0001;
                    if (ctl.is_external_data_move)
                    begin
                        mode_nxt = cycle_timing_pkg::seq_xdata;
                        xaddr_nxt = xdata_addr_in;
                        xwrite_nxt = ctl.external_data_move_write;
                        cyc_left_nxt = stretch_r;
                        strobe_cnt_nxt = (stretch_r == 3'h0) ? cycle_timing_pkg::strobe_clocks_zero
                            : 5'(stretch_r * cycle_timing_pkg::strobe_clocks_per_unit);
                    end
                    else if (ctl.total_cycles == 3'h1)
                    begin
                        done_nxt = 1'b1;
                        if (idle_bit_r || (idle_wr && idle_wdata))
                            mode_nxt = cycle_timing_pkg::seq_idle;
                    end
                    else
                    begin
                        mode_nxt = cycle_timing_pkg::seq_exec;
                        cyc_left_nxt = ctl.total_cycles - 3'h2;
                    end
                end
            end
            cycle_timing_pkg::seq_exec:
            begin
                if (ctl.cycle_end)
                begin
                    pc_nxt = ctl.is_jump ? pc_r : pc_r + 16'h0001;
                    fetch_nxt = !ctl.is_jump || cyc_left_r != 3'h0;
                    if (cyc_left_r == 3'h0)
                    begin
                        done_nxt = 1'b1;
                        mode_nxt = idle_bit_r ? cycle_timing_pkg::seq_idle : cycle_timing_pkg::seq_fetch;
                    end
                    else
                        cyc_left_nxt = cyc_left_r - 3'h1;
                end
            end
            cycle_timing_pkg::seq_xdata:
            begin
                if (strobe_cnt_r != 5'h00 && (ctl.phase[1] || cyc_left_r != 3'h0 || stretch_r != 3'h0))
                begin
                    rd_n_nxt = xwrite_r;
                    wr_n_nxt = !xwrite_r;
                    strobe_cnt_nxt = strobe_cnt_r - 5'h01;
                end
                if (ctl.cycle_end)
                begin
                    if (cyc_left_r == 3'h0)
                    begin
                        done_nxt = 1'b1;
                        mode_nxt = idle_bit_r ? cycle_timing_pkg::seq_idle : cycle_timing_pkg::seq_fetch;
                    end
                    else
                        cyc_left_nxt = cyc_left_r - 3'h1;
                end
            end
            cycle_timing_pkg::seq_idle:
            begin
                if (irq_pending)
                begin
                    idle_bit_nxt = 1'b0;
                    irq_ack_nxt = 1'b1;
                    mode_nxt = cycle_timing_pkg::seq_fetch;
                end
            end
            default: mode_nxt = cycle_timing_pkg::seq_fetch;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_r <= cycle_timing_pkg::seq_fetch;
            stretch_r <= cycle_timing_pkg::stretch_reset;
            idle_bit_r <= 1'b0;
            pc_r <= cycle_timing_pkg::pc_reset;
            opcode_r <= 8'h00;
            cyc_left_r <= 3'h0;
            strobe_cnt_r <= 5'h00;
            xwrite_r <= 1'b0;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            xaddr_r <= 16'h0000;
            port_r <= 8'hff;
            irq_ack_r <= 1'b0;
            done_r <= 1'b0;
            fetch_r <= 1'b0;
        end
        else if (core_rst)
        begin
            mode_r <= cycle_timing_pkg::seq_fetch;
            stretch_r <= cycle_timing_pkg::stretch_reset;
            idle_bit_r <= 1'b0;
            pc_r <= cycle_timing_pkg::pc_reset;
            opcode_r <= 8'h00;
            cyc_left_r <= 3'h0;
            strobe_cnt_r <= 5'h00;
            xwrite_r <= 1'b0;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            xaddr_r <= 16'h0000;
            port_r <= 8'hff;
            irq_ack_r <= 1'b0;
            done_r <= 1'b0;
            fetch_r <= 1'b0;
        end
        else
        begin
            mode_r <= mode_nxt;
            stretch_r <= stretch_nxt;
            idle_bit_r <= idle_bit_nxt;
            pc_r <= pc_nxt;
            opcode_r <= opcode_nxt;
            cyc_left_r <= cyc_left_nxt;
            strobe_cnt_r <= strobe_cnt_nxt;
            xwrite_r <= xwrite_nxt;
            rd_n_r <= rd_n_nxt;
            wr_n_r <= wr_n_nxt;
            xaddr_r <= xaddr_nxt;
            port_r <= port_nxt;
            irq_ack_r <= irq_ack_nxt;
            done_r <= done_nxt;
            fetch_r <= fetch_nxt;
        end
    end

    // phases stop while idle; they keep running in reset so the hold count can expire
    assign ctl.hold = (mode_r == cycle_timing_pkg::seq_idle);
    assign ctl.opcode = (mode_r == cycle_timing_pkg::seq_fetch) ? code_byte : opcode_r;

    assign code_addr = pc_r;
    assign fetch_strobe = fetch_r;
    assign ale = (mode_r == cycle_timing_pkg::seq_idle) || (ctl.phase == cycle_timing_pkg::cycle_state_one);
    assign program_store_strobe_n = (mode_r == cycle_timing_pkg::seq_idle)
        || (mode_r == cycle_timing_pkg::seq_xdata) || !ctl.phase[1];
    assign xdata_addr = xaddr_r;
    assign rd_n = rd_n_r;
    assign wr_n = wr_n_r;
    assign port_out = port_r;
    assign cycle_state = ctl.phase;
    assign core_clk_en = (mode_r != cycle_timing_pkg::seq_idle);
    assign idle_active = idle_bit_r;
    assign data_access_stretch_sel = stretch_r;
    assign internal_reset = core_rst;
    assign irq_ack = irq_ack_r;
    assign instr_done = done_r;
endmodule
`default_nettype wire

// File: tb/ext_data_model.sv
// external data memory model that times the access strobes
`timescale 1ns/10ps
`default_nettype none
module ext_data_model (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [15:0] xdata_addr,
    output logic [4:0] rd_width,
    output logic [4:0] wr_width,
    output logic [15:0] seen_addr
);
    logic [4:0] rd_cnt;
    logic [4:0] wr_cnt;
    // counts low clocks of each strobe, keeps the width once it is released
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_cnt <= 5'h00;
            wr_cnt <= 5'h00;
            rd_width <= 5'h00;
            wr_width <= 5'h00;
            seen_addr <= 16'h0000;
        end
        else
        begin
            rd_cnt <= rd_n ? 5'h00 : rd_cnt + 5'h01;
            wr_cnt <= wr_n ? 5'h00 : wr_cnt + 5'h01;
            if (rd_n && rd_cnt != 5'h00)
                rd_width <= rd_cnt;
            if (wr_n && wr_cnt != 5'h00)
                wr_width <= wr_cnt;
            if (!rd_n || !wr_n)
                seen_addr <= xdata_addr;
        end
    end
endmodule
`default_nettype wire

// File: tb/cpu_cycle_timing_stretch_idle_chk.sv
// assertions on the sequencer ports
`timescale 1ns/10ps
`default_nettype none
module cpu_cycle_timing_stretch_idle_chk #(
    parameter int unsigned wdt_delay = cycle_timing_pkg::wdt_reset_delay_clocks
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic irq_pending,
    input wire logic wdt_timeout,
    input wire logic wdt_clear,
    input wire logic wdt_reset_en,
    input wire logic [15:0] code_addr,
    input wire logic fetch_strobe,
    input wire logic ale,
    input wire logic program_store_strobe_n,
    input wire logic [15:0] xdata_addr,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] port_out,
    input wire logic [1:0] cycle_state,
    input wire logic core_clk_en,
    input wire logic idle_active,
    input wire logic [2:0] data_access_stretch_sel,
    input wire logic internal_reset
);
    localparam int wd_hi = wdt_delay + 16;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    property p_fetch_gap;
        fetch_strobe |=> !fetch_strobe [*3];
    endproperty
    a_fetch_gap: assert property (p_fetch_gap) else $error("fetches closer than four clocks");
    property p_fetch_state;
        fetch_strobe |-> $past(cycle_state) == cycle_timing_pkg::cycle_state_four;
    endproperty
    a_fetch_state: assert property (p_fetch_state) else $error("fetch not after state four");
    property p_excl;
        rd_n || wr_n;
    endproperty
    a_excl: assert property (p_excl) else $error("read and write strobes both low");
    property p_idle_pins;
        !core_clk_en |-> ale && program_store_strobe_n && idle_active;
    endproperty
    a_idle_pins: assert property (p_idle_pins) else $error("idle pin levels wrong");
    property p_idle_hold;
        !core_clk_en && !$past(core_clk_en) |-> $stable(port_out) && $stable(code_addr);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("state moved during idle");
    property p_wake;
        idle_active && irq_pending |-> ##[1:8] !idle_active;
    endproperty
    a_wake: assert property (p_wake) else $error("interrupt did not end idle");
    property p_rd_min;
        $fell(rd_n) |=> !rd_n;
    endproperty
    a_rd_min: assert property (p_rd_min) else $error("read strobe shorter than two clocks");
    property p_wr_min;
        $fell(wr_n) |=> !wr_n;
    endproperty
    a_wr_min: assert property (p_wr_min) else $error("write strobe shorter than two clocks");
    property p_addr_hold;
        !rd_n && !$fell(rd_n) |-> $stable(xdata_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("data address moved in a read");
    property p_rst_vals;
        internal_reset && $past(internal_reset) |->
            code_addr == cycle_timing_pkg::pc_reset && !idle_active
            && data_access_stretch_sel == cycle_timing_pkg::stretch_reset;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("reset values not held");
    property p_wdt;
        $rose(wdt_timeout) && wdt_reset_en |-> ##[1:wd_hi] (internal_reset || wdt_clear);
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog reset missing");
    c_idle: cover property (idle_active ##[1:64] !idle_active);
    c_rd: cover property ($fell(rd_n));
    c_wr: cover property ($fell(wr_n));
endmodule
bind cpu_cycle_timing_stretch_idle cpu_cycle_timing_stretch_idle_chk #(.wdt_delay(wdt_delay)) chk_u (
    .mclk(mclk), .rst_b(rst_b), .irq_pending(irq_pending), .wdt_timeout(wdt_timeout),
    .wdt_clear(wdt_clear), .wdt_reset_en(wdt_reset_en), .code_addr(code_addr), .fetch_strobe(fetch_strobe),
    .ale(ale), .program_store_strobe_n(program_store_strobe_n), .xdata_addr(xdata_addr), .rd_n(rd_n),
    .wr_n(wr_n), .port_out(port_out), .cycle_state(cycle_state), .core_clk_en(core_clk_en),
    .idle_active(idle_active), .data_access_stretch_sel(data_access_stretch_sel),
    .internal_reset(internal_reset));
`default_nettype wire

// File: tb/cpu_cycle_timing_stretch_idle_bench.sv
// self-checking bench for the machine-cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module cpu_cycle_timing_stretch_idle_bench;
    localparam int unsigned wd = 16;
    logic mclk, rst_b, rst_pin, stretch_wr, idle_wr, idle_wdata, irq_pending;
    logic wdt_timeout, wdt_clear, wdt_reset_en, fetch_strobe, ale, program_store_strobe_n;
    logic rd_n, wr_n, core_clk_en, idle_active, internal_reset, irq_ack, instr_done;
    logic [7:0] code_byte, port_in, port_out;
    logic [2:0] stretch_wdata, data_access_stretch_sel;
    logic [15:0] xdata_addr_in, xdata_addr, code_addr, seen_addr;
    logic [1:0] cycle_state;
    logic [4:0] rd_width, wr_width;
    int mismatches = 0;
    int compares = 0;
    cpu_cycle_timing_stretch_idle #(.wdt_delay(wd)) dut_u (
        .mclk(mclk), .rst_b(rst_b), .rst_pin(rst_pin), .code_byte(code_byte), .stretch_wr(stretch_wr),
        .stretch_wdata(stretch_wdata), .idle_wr(idle_wr), .idle_wdata(idle_wdata), .irq_pending(irq_pending),
        .wdt_timeout(wdt_timeout), .wdt_clear(wdt_clear), .wdt_reset_en(wdt_reset_en),
        .xdata_addr_in(xdata_addr_in), .port_in(port_in), .code_addr(code_addr), .fetch_strobe(fetch_strobe),
        .ale(ale), .program_store_strobe_n(program_store_strobe_n), .xdata_addr(xdata_addr), .rd_n(rd_n),
        .wr_n(wr_n), .port_out(port_out), .cycle_state(cycle_state), .core_clk_en(core_clk_en),
        .idle_active(idle_active), .data_access_stretch_sel(data_access_stretch_sel),
        .internal_reset(internal_reset), .irq_ack(irq_ack), .instr_done(instr_done));
    ext_data_model ext_u (
        .mclk(mclk), .rst_b(rst_b), .rd_n(rd_n), .wr_n(wr_n), .xdata_addr(xdata_addr),
        .rd_width(rd_width), .wr_width(wr_width), .seen_addr(seen_addr));
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task automatic must(input logic ok, input string what);
        check(ok, 1'b1, what);
        if (ok !== 1'b1)
            stop_test();
    endtask
    task automatic step;
        @(posedge mclk);
        #1;
    endtask
    task automatic gap(output int n);
        for (n = 1; n < 64; n++)
        begin
            step();
            if (fetch_strobe === 1'b1)
                break;
        end
    endtask
    task automatic wait_fetch;
        int n;
        for (n = 0; n < 64 && fetch_strobe !== 1'b1; n++)
            step();
        must(fetch_strobe, "fetch timeout");
    endtask
    task automatic t_nop;
        int n;
        logic [15:0] pc;
        wait_fetch();
        pc = code_addr;
        check(cycle_state, cycle_timing_pkg::cycle_state_one, "state after fetch");
        gap(n);
        check(n, cycle_timing_pkg::states_per_cycle, "one-cycle opcode");
        check(code_addr, pc + 16'h0001, "one byte per cycle");
        check(instr_done, 1'b1, "one-cycle opcode done");
    endtask
    task automatic t_jump;
        int n;
        wait_fetch();
        repeat (3) @(posedge mclk);
        code_byte <= cycle_timing_pkg::opcode_ljmp;
        @(posedge mclk);
        code_byte <= 8'h00;
        #1;
        gap(n);
        check(n, 8, "jump extra cycle");
    endtask
    task automatic t_move(input logic [2:0] s, input logic wr);
        int n;
        @(posedge mclk);
        stretch_wr <= 1'b1;
        stretch_wdata <= s;
        @(posedge mclk);
        stretch_wr <= 1'b0;
        step();
        check(data_access_stretch_sel, s, "stretch field");
        wait_fetch();
        @(posedge mclk);
        code_byte <= wr ? cycle_timing_pkg::opcode_external_data_move_wr : cycle_timing_pkg::opcode_external_data_move_rd;
        xdata_addr_in <= {8'h5a, 5'h00, s};
        repeat (3) @(posedge mclk);
        code_byte <= 8'h00;
        #1;
        wait_fetch();
        gap(n);
        check(n, 4 * (s + 2), "data move clocks");
        check(wr ? wr_width : rd_width, (s == 3'h0) ? 2 : 4 * s, "strobe width");
        check(seen_addr, {8'h5a, 5'h00, s}, "data address");
        gap(n);
        check(n, 4, "next opcode unstretched");
    endtask
    task automatic t_idle(input logic by_irq);
        int n;
        logic [15:0] pc;
        logic [7:0] po;
        logic [2:0] sv;
        logic seen;
        wait_fetch();
        @(posedge mclk);
        idle_wr <= 1'b1;
        idle_wdata <= 1'b1;
        @(posedge mclk);
        idle_wr <= 1'b0;
        #1;
        for (n = 0; n < 32 && core_clk_en !== 1'b0; n++)
            step();
        must(idle_active, "idle entry");
        pc = code_addr;
        po = port_out;
        sv = data_access_stretch_sel;
        @(posedge mclk);
        port_in <= ~port_in;
        stretch_wr <= 1'b1;
        stretch_wdata <= ~sv;
        @(posedge mclk);
        stretch_wr <= 1'b0;
        repeat (20) step();
        check(code_addr, pc, "pc frozen");
        check(port_out, po, "port held");
        check({ale, program_store_strobe_n, core_clk_en}, 3'b110, "idle pins");
        check(data_access_stretch_sel, sv, "stretch write in idle");
        seen = 1'b0;
        @(posedge mclk);
        if (by_irq)
            irq_pending <= 1'b1;
        else
            rst_pin <= 1'b1;
        for (n = 0; n < 12; n++)
        begin
            step();
            seen = seen | (by_irq ? irq_ack : internal_reset);
        end
        @(posedge mclk);
        irq_pending <= 1'b0;
        rst_pin <= 1'b0;
        check(seen, 1'b1, "wake event");
        #1;
        for (n = 0; n < 32 && internal_reset !== 1'b0; n++)
            step();
        must(!internal_reset, "reset release");
        check(idle_active, 1'b0, "idle bit cleared");
        if (!by_irq)
        begin
            check(code_addr, cycle_timing_pkg::pc_reset, "restart address");
            check(data_access_stretch_sel, cycle_timing_pkg::stretch_reset, "stretch reset");
        end
        wait_fetch();
    endtask
    task automatic t_wdt(input logic clr);
        int n;
        @(posedge mclk);
        wdt_reset_en <= 1'b1;
        wdt_timeout <= 1'b1;
        @(posedge mclk);
        wdt_timeout <= 1'b0;
        if (clr)
        begin
            repeat (3) @(posedge mclk);
            wdt_clear <= 1'b1;
            @(posedge mclk);
            wdt_clear <= 1'b0;
        end
        #1;
        for (n = 1; n < wd + 40 && internal_reset !== 1'b1; n++)
            step();
        if (clr)
            check(internal_reset, 1'b0, "cleared watchdog");
        else
            check(n + 2 >= wd && n <= wd + 8, 1'b1, "watchdog delay");
        @(posedge mclk);
        wdt_reset_en <= 1'b0;
        #1;
        for (n = 0; n < 32 && internal_reset !== 1'b0; n++)
            step();
        must(!internal_reset, "watchdog reset release");
    endtask
    initial
    begin
        rst_b = 1'b0;
        {rst_pin, stretch_wr, idle_wr, idle_wdata, irq_pending} = 5'h00;
        {wdt_timeout, wdt_clear, wdt_reset_en} = 3'h0;
        code_byte = 8'h00;
        port_in = 8'h3c;
        stretch_wdata = 3'h0;
        xdata_addr_in = 16'h0000;
        repeat (12) @(posedge mclk);
        check(code_addr, cycle_timing_pkg::pc_reset, "pc at reset");
        check(data_access_stretch_sel, cycle_timing_pkg::stretch_reset, "stretch at reset");
        check({rd_n, wr_n}, 2'b11, "strobes at reset");
        rst_b <= 1'b1;
        t_nop();
        t_jump();
        for (int s = 0; s < 8; s++)
        begin
            t_move(s[2:0], 1'b0);
            t_move(s[2:0], 1'b1);
        end
        t_idle(1'b1);
        t_idle(1'b0);
        t_wdt(1'b1);
        t_wdt(1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
